// ### logic/pulse_timer.sv
// Purpose: Periodic gating pulse with programmable width, period and delay
// Assumes: Classic Wishbone slave, 32-bit data, one clock
// Notes:   All timing is counted on a 10 MHz enable from the system clock
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - In internal mode one pulse of the set width is sent in every period while enabled.
// - Timing is counted on a 10 MHz pulse clock, giving a 100 ns delay resolution.
// - With the delayed option the leading edge is held off by the first delay from period start.
// - With sweeping on the delay moves from start toward stop by one step per step time.
// - The sweep runs only while its switch is on; otherwise the fixed first delay is used.
// - A start above stop sweeps the delay downward.
// - An error is raised while delay plus width exceeds the period or the width reaches it, and drops otherwise.
// - The generator shall make gating pulses down to 10 ns; the shortest pulse here is one 100 ns tick.
// - The first delay is measured from the internal or external trigger.
// - The next leading edge must come later than the end of the previous pulse, else error.
module pulse_timer
    import pulse_timer_pkg::*;
#(
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Trigger pin
    input  wire logic        EXT_TRIG,
    // Timing outputs
    output logic             PULSE_OUT,
    output logic             SYNC_OUT,
    output logic             ERROR_OUT,
    // Interrupt
    output logic             IRQ
);
    import pulse_timer_pkg::*;

    generate
        if (CNT_W < 16 || CNT_W > 31) begin : g_bad_width
            $error("CNT_W must lie between 16 and 31");
        end
    endgenerate

    step_if #(.CNT_W(CNT_W)) sweep_bus ();

    // Register file
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CNT_W-1:0]  width_reg;
    logic [CNT_W-1:0]  period_reg;
    logic [CNT_W-1:0]  delay1_reg;
    logic [CNT_W-1:0]  start_reg;
    logic [CNT_W-1:0]  stop_reg;
    logic [CNT_W-1:0]  size_reg;
    logic [CNT_W-1:0]  dwell_reg;
    logic [EV_W-1:0]   status_reg;
    logic [EV_W-1:0]   mask_reg;
    logic              ack_reg;
    logic [31:0]       rdata_reg;

    // Timing state
    logic [$clog2(PULSE_DIV)-1:0] div_reg;
    logic                         tick_reg;
    logic [CNT_W-1:0]             phase_reg;
    logic [CNT_W-1:0]             eff_delay_reg;
    run_state_t                   run_reg;
    run_state_t                   run_next;
    logic                         pulse_reg;
    logic                         sync_reg;
    logic                         error_reg;
    logic                         irq_reg;
    logic                         trig_meta_reg;
    logic                         trig_sync_reg;
    logic                         trig_prev_reg;

    // Bus decode
    wire        bus_req   = WB_CYC_I && WB_STB_I;
    wire        bus_wr    = bus_req && WB_WE_I && ack_reg && (WB_SEL_I == 4'hf);
    wire        wr_ctrl   = bus_wr && (WB_ADR_I == OFS_CTRL);
    wire        wr_width  = bus_wr && (WB_ADR_I == OFS_WIDTH);
    wire        wr_period = bus_wr && (WB_ADR_I == OFS_PERIOD);
    wire        wr_delay1 = bus_wr && (WB_ADR_I == OFS_DELAY1);
    wire        wr_start  = bus_wr && (WB_ADR_I == OFS_START);
    wire        wr_stop   = bus_wr && (WB_ADR_I == OFS_STOP);
    wire        wr_size   = bus_wr && (WB_ADR_I == OFS_STEP_SIZE);
    wire        wr_dwell  = bus_wr && (WB_ADR_I == OFS_STEP_TIME);
    wire        wr_status = bus_wr && (WB_ADR_I == OFS_STATUS);
    wire        wr_mask   = bus_wr && (WB_ADR_I == OFS_IRQ_MASK);
    wire [CNT_W-1:0] wdata = WB_DAT_I[CNT_W-1:0];

    wire enable    = ctrl_reg[CTRL_ENABLE];
    wire delayed   = ctrl_reg[CTRL_DELAYED];
    wire step_on   = ctrl_reg[CTRL_STEP_ON];
    wire ext_mode  = ctrl_reg[CTRL_EXT_TRG];

    // Period and pulse timing
    wire             trig_rise  = trig_sync_reg && !trig_prev_reg;
    wire             counting   = (run_reg != RUN_IDLE);
    wire             last_phase = ({1'b0, phase_reg} + 1'b1) >= {1'b0, period_reg};
    wire             per_start  = tick_reg && enable && !counting
                                  && (!ext_mode || trig_rise);
    wire             wrap_free  = tick_reg && (run_reg == RUN_FREE) && last_phase;
    wire             new_period = per_start || wrap_free;
    wire [CNT_W-1:0] delay_sel  = !delayed ? '0
                                  : (step_on ? sweep_bus.cur : delay1_reg);
    wire [CNT_W:0]   pulse_end  = {1'b0, eff_delay_reg} + {1'b0, width_reg};
    wire             in_pulse   = counting && (width_reg != '0)
                                  && (phase_reg >= eff_delay_reg)
                                  && ({1'b0, phase_reg} < pulse_end);
    wire [CNT_W:0]   fit_sum    = {1'b0, delay_sel} + {1'b0, width_reg};
    wire             misfit     = (fit_sum > {1'b0, period_reg})
                                  || (width_reg >= period_reg);
    wire [EV_W-1:0]  events;
    wire             err_rise   = misfit && !error_reg;

    assign events[EV_PERIOD] = new_period;
    assign events[EV_ERROR]  = err_rise;
    assign events[EV_WRAP]   = sweep_bus.wrap;

    always_comb begin
        run_next = run_reg;
        case (run_reg)
            RUN_IDLE: begin
                if (per_start) begin
                    run_next = ext_mode ? RUN_SINGLE : RUN_FREE;
                end
            end
            RUN_FREE: begin
                if (!enable || ext_mode) begin
                    run_next = RUN_IDLE;
                end
            end
            RUN_SINGLE: begin
                if (!enable || (tick_reg && last_phase)) begin
                    run_next = RUN_IDLE;
                end
            end
            default: begin
                run_next = RUN_IDLE;
            end
        endcase
    end

    // Sweeper hookup
    assign sweep_bus.tick  = tick_reg;
    assign sweep_bus.run   = step_on && delayed && enable;
    assign sweep_bus.start = start_reg;
    assign sweep_bus.stop  = stop_reg;
    assign sweep_bus.size  = size_reg;
    assign sweep_bus.dwell = dwell_reg;

    delay_sweeper #(.CNT_W(CNT_W)) u_sweeper (
        .clk    (CLK),
        .arst_n (ARST_N),
        .sw     (sweep_bus)
    );

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (WB_ADR_I)
            OFS_CTRL:      rd_mux[CTRL_W-1:0] = ctrl_reg;
            OFS_WIDTH:     rd_mux[CNT_W-1:0]  = width_reg;
            OFS_PERIOD:    rd_mux[CNT_W-1:0]  = period_reg;
            OFS_DELAY1:    rd_mux[CNT_W-1:0]  = delay1_reg;
            OFS_START:     rd_mux[CNT_W-1:0]  = start_reg;
            OFS_STOP:      rd_mux[CNT_W-1:0]  = stop_reg;
            OFS_STEP_SIZE: rd_mux[CNT_W-1:0]  = size_reg;
            OFS_STEP_TIME: rd_mux[CNT_W-1:0]  = dwell_reg;
            OFS_STATUS:    rd_mux[EV_W-1:0]   = status_reg;
            OFS_IRQ_MASK:  rd_mux[EV_W-1:0]   = mask_reg;
            OFS_STATE:     rd_mux[ST_W-1:0]   = {sweep_bus.run, pulse_reg, error_reg};
            OFS_CUR_DELAY: rd_mux[CNT_W-1:0]  = eff_delay_reg;
            default:       rd_mux             = 32'h0000_0000;
        endcase
    end

    // Bus handshake: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= bus_req && !ack_reg;
            rdata_reg <= rd_mux;
        end
    end

    // Control registers; writes land on the acknowledged edge
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg   <= RST_CTRL;
            width_reg  <= RST_WIDTH[CNT_W-1:0];
            period_reg <= RST_PERIOD[CNT_W-1:0];
            delay1_reg <= RST_DELAY1[CNT_W-1:0];
            start_reg  <= RST_START[CNT_W-1:0];
            stop_reg   <= RST_STOP[CNT_W-1:0];
            size_reg   <= RST_STEP_SIZE[CNT_W-1:0];
            dwell_reg  <= RST_STEP_TIME[CNT_W-1:0];
            mask_reg   <= '0;
        end else begin
            if (wr_ctrl)   ctrl_reg   <= WB_DAT_I[CTRL_W-1:0];
            if (wr_width)  width_reg  <= wdata;
            if (wr_period) period_reg <= wdata;
            if (wr_delay1) delay1_reg <= wdata;
            if (wr_start)  start_reg  <= wdata;
            if (wr_stop)   stop_reg   <= wdata;
            if (wr_size)   size_reg   <= wdata;
            if (wr_dwell)  dwell_reg  <= wdata;
            if (wr_mask)   mask_reg   <= WB_DAT_I[EV_W-1:0];
        end
    end

    // Sticky events: a new event wins over a write-one clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_reg <= '0;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? WB_DAT_I[EV_W-1:0] : '0)) | events;
            irq_reg    <= |(status_reg & mask_reg);
        end
    end

    // Pulse clock enable; a one-cycle pulse every PULSE_DIV system cycles
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == '0);
            div_reg  <= (div_reg == ($clog2(PULSE_DIV))'(PULSE_DIV - 1))
                        ? '0 : div_reg + 1'b1;
        end
    end

    // Trigger pin synchroniser and edge history
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end else begin
            trig_meta_reg <= EXT_TRIG;
            trig_sync_reg <= trig_meta_reg;
            if (tick_reg) trig_prev_reg <= trig_sync_reg;
        end
    end

    // Period counter; the delay is taken once per period so a sweep step
    // never tears a pulse in half
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            run_reg       <= RUN_IDLE;
            phase_reg     <= '0;
            eff_delay_reg <= '0;
        end else begin
            run_reg <= run_next;
            if (new_period) begin
                phase_reg     <= '0;
                eff_delay_reg <= delay_sel;
            end else if (tick_reg && counting) begin
                phase_reg <= phase_reg + 1'b1;
            end
        end
    end

    // Outputs, each from its own flop
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pulse_reg <= 1'b0;
            sync_reg  <= 1'b0;
            error_reg <= 1'b0;
        end else begin
            // Moves only off a tick edge, so a disable never leaves a half-tick sliver
            if (!tick_reg) pulse_reg <= in_pulse && enable;
            if (new_period)    sync_reg <= 1'b1;
            else if (tick_reg) sync_reg <= 1'b0;
            error_reg <= misfit;
        end
    end

    assign WB_ACK_O  = ack_reg;
    assign WB_DAT_O  = rdata_reg;
    assign PULSE_OUT = pulse_reg;
    assign SYNC_OUT  = sync_reg;
    assign ERROR_OUT = error_reg;
    assign IRQ       = irq_reg;
endmodule
`default_nettype wire

// ### logic/pulse_timer_pkg.sv
// Purpose: Shared constants of the stepped delay pulse timer
// Assumes: 20 MHz system clock, 10 MHz pulse clock derived by enable
// Notes:   Register offsets are byte addresses on a 32-bit classic Wishbone
`default_nettype none
package pulse_timer_pkg;
    // Clock rates and pulse clock divider
    localparam int unsigned SYS_CLK_HZ   = 20_000_000;
    localparam int unsigned PULSE_CLK_HZ = 10_000_000;
    localparam int unsigned PULSE_DIV    = SYS_CLK_HZ / PULSE_CLK_HZ;
    localparam int unsigned TICK_NS      = 1_000_000_000 / PULSE_CLK_HZ;
    localparam int unsigned MIN_DELAY_NS = 100;
    localparam int unsigned MIN_DELAY_TICKS =
        (MIN_DELAY_NS + TICK_NS - 1) / TICK_NS;
    localparam int unsigned MIN_WIDTH_NS = 10;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_WIDTH     = 8'h04;
    localparam logic [7:0] OFS_PERIOD    = 8'h08;
    localparam logic [7:0] OFS_DELAY1    = 8'h0c;
    localparam logic [7:0] OFS_START     = 8'h10;
    localparam logic [7:0] OFS_STOP      = 8'h14;
    localparam logic [7:0] OFS_STEP_SIZE = 8'h18;
    localparam logic [7:0] OFS_STEP_TIME = 8'h1c;
    localparam logic [7:0] OFS_STATUS    = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h24;
    localparam logic [7:0] OFS_STATE     = 8'h28;
    localparam logic [7:0] OFS_CUR_DELAY = 8'h2c;

    // Control bit positions
    localparam int unsigned CTRL_ENABLE  = 0;
    localparam int unsigned CTRL_DELAYED = 1;
    localparam int unsigned CTRL_STEP_ON = 2;
    localparam int unsigned CTRL_EXT_TRG = 3;
    localparam int unsigned CTRL_W       = 4;

    // Event bit positions, shared by status and mask
    localparam int unsigned EV_PERIOD    = 0;
    localparam int unsigned EV_ERROR     = 1;
    localparam int unsigned EV_WRAP      = 2;
    localparam int unsigned EV_W         = 3;

    // Live state bit positions
    localparam int unsigned ST_ERROR     = 0;
    localparam int unsigned ST_PULSE     = 1;
    localparam int unsigned ST_SWEEP     = 2;
    localparam int unsigned ST_W         = 3;

    // Reset values in pulse clock ticks (100 ns each)
    localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
    localparam logic [31:0] RST_WIDTH     = 32'h0000_01f4;
    localparam logic [31:0] RST_PERIOD    = 32'h0000_2710;
    localparam logic [31:0] RST_DELAY1    = 32'h0000_03e8;
    localparam logic [31:0] RST_START     = 32'h0000_03e8;
    localparam logic [31:0] RST_STOP      = 32'h0000_2328;
    localparam logic [31:0] RST_STEP_SIZE = 32'h0000_0005;
    localparam logic [31:0] RST_STEP_TIME = 32'h0001_86a0;

    typedef enum logic [1:0] {
        RUN_IDLE   = 2'b00,
        RUN_FREE   = 2'b01,
        RUN_SINGLE = 2'b10
    } run_state_t;
endpackage
`default_nettype wire

// ### logic/step_if.sv
// Purpose: Carries sweep settings and the current delay between timer and sweeper
// Assumes: Single clock domain
// Notes:   Counts are pulse clock ticks
`timescale 1ns/100ps
`default_nettype none
interface step_if #(parameter int unsigned CNT_W = 24);
    logic             tick;
    logic             run;
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] stop;
    logic [CNT_W-1:0] size;
    logic [CNT_W-1:0] dwell;
    logic [CNT_W-1:0] cur;
    logic             wrap;

    modport owner   (output tick, run, start, stop, size, dwell, input cur, wrap);
    modport sweeper (input tick, run, start, stop, size, dwell, output cur, wrap);
endinterface
`default_nettype wire

// ### logic/delay_sweeper.sv
// Purpose: Steps the pulse delay from start toward stop, one step per dwell
// Assumes: tick is the one-cycle pulse clock enable
// Notes:   Direction follows the order of start and stop
`timescale 1ns/100ps
`default_nettype none
module delay_sweeper #(
    parameter int unsigned CNT_W = 24
) (
    input wire logic clk,
    input wire logic arst_n,
    step_if.sweeper  sw
);
    logic [CNT_W-1:0] cur_reg;
    logic [CNT_W-1:0] cur_next;
    logic [CNT_W-1:0] dwell_reg;
    logic             wrap_reg;

    wire              dir_up    = sw.start <= sw.stop;
    wire              at_stop   = cur_reg == sw.stop;
    wire [CNT_W:0]    up_sum    = {1'b0, cur_reg} + {1'b0, sw.size};
    wire [CNT_W-1:0]  down_room = cur_reg - sw.stop;
    wire              dwell_end = ({1'b0, dwell_reg} + 1'b1) >= {1'b0, sw.dwell};

    // Clamp to stop so the last step lands exactly on it
    assign cur_next = dir_up
        ? ((up_sum >= {1'b0, sw.stop}) ? sw.stop : up_sum[CNT_W-1:0])
        : ((down_room <= sw.size) ? sw.stop : cur_reg - sw.size);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_reg   <= '0;
            dwell_reg <= '0;
            wrap_reg  <= 1'b0;
        end else begin
            wrap_reg <= 1'b0;
            if (!sw.run) begin
                cur_reg   <= sw.start;
                dwell_reg <= '0;
            end else if (sw.tick) begin
                if (dwell_end) begin
                    dwell_reg <= '0;
                    if (at_stop) begin
                        cur_reg  <= sw.start;
                        wrap_reg <= 1'b1;
                    end else begin
                        cur_reg <= cur_next;
                    end
                end else begin
                    dwell_reg <= dwell_reg + 1'b1;
                end
            end
        end
    end

    assign sw.cur  = cur_reg;
    assign sw.wrap = wrap_reg;
endmodule
`default_nettype wire

// ### sim/pulse_timer_properties.sv
// Purpose: Port-level assertions for the pulse timer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only the top-level ports; bound from the bench
`timescale 1ns/100ps
`default_nettype none
module pulse_timer_properties
    import pulse_timer_pkg::*;
#(
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        ARST_N,
    // Bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Pins
    input wire logic        EXT_TRIG,
    input wire logic        PULSE_OUT,
    input wire logic        SYNC_OUT,
    input wire logic        ERROR_OUT,
    input wire logic        IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered in the next cycle");
    a_ack_has_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    a_unmapped_zero: assert property (WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) > 8'h2f
        |-> WB_DAT_O == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    a_sync_one_tick: assert property ($rose(SYNC_OUT) |=> SYNC_OUT ##1 !SYNC_OUT)
        else $error("sync not one pulse tick long");
    a_sync_spacing: assert property ($rose(SYNC_OUT) |-> ##2 !SYNC_OUT[*2])
        else $error("sync periods too close");
    a_pulse_whole_tick: assert property ($rose(PULSE_OUT) |=> PULSE_OUT)
        else $error("pulse shorter than one pulse tick");
    // Reset is asynchronous, so this one must not be disabled by it
    a_reset_quiet: assert property (@(posedge CLK) disable iff (1'b0)
        !ARST_N |-> !(PULSE_OUT || SYNC_OUT || IRQ || WB_ACK_O || ERROR_OUT))
        else $error("output active during reset");
endmodule
`default_nettype wire

// ### sim/pulse_meter_model.sv
// Purpose: Behavioural power meter triggered by the sync output
// Assumes: Sync and pulse are sampled on the system clock
// Notes:   Results of a period are published at the next trigger
`timescale 1ns/100ps
`default_nettype none
module pulse_meter_model #(
    parameter int WINDOW = 400
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Inputs from the timer
    input wire logic sync_in,
    input wire logic pulse_in,
    // Results in clock cycles
    output int       n_trig,
    output int       p_lead,
    output int       p_width,
    output int       p_period
);
    logic sync_d;
    logic pulse_d;
    int   age;
    int   lead;
    int   width;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {sync_d, pulse_d} <= 2'b00;
            {n_trig, p_lead, p_width, p_period, age, width} <= '0;
            lead <= -1;
        end else begin
            sync_d <= sync_in;
            pulse_d <= pulse_in;
            if (sync_in && !sync_d) begin
                n_trig <= n_trig + 1;
                p_period <= age;
                p_lead <= lead;
                p_width <= width;
                age <= 1;
                lead <= (pulse_in && !pulse_d) ? 0 : -1;
                width <= int'(pulse_in);
            end else if (age > 0 && age < WINDOW) begin
                age <= age + 1;
                if (pulse_in && !pulse_d && lead < 0) lead <= age;
                if (pulse_in) width <= width + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/stepped_delay_pulse_timer_tb.sv
// Purpose: Self-checking bench of the pulse timer
// Assumes: 20 MHz clock, register access over classic Wishbone
// Notes:   Small tick counts keep the run short
`timescale 1ns/100ps
`default_nettype none
module stepped_delay_pulse_timer_tb;
    import pulse_timer_pkg::*;
    localparam int LIMIT = 20000;
    logic        clk = 1'b0;
    // Starts unknown so the drive to zero at time 0 is a falling edge
    logic        arst_n;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic        ext_trig = 1'b0;
    logic [31:0] wb_rdat;
    logic        wb_ack, pulse, sync, err, irq;
    int          n_errors = 0, cmp_count = 0, cycles = 0;
    int          n_trig, m_lead, m_width, m_period;

    always #25 clk = ~clk;

    pulse_timer #(.CNT_W(24)) dut_u (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(wb_cyc),
        .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
        .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .EXT_TRIG(ext_trig),
        .PULSE_OUT(pulse), .SYNC_OUT(sync), .ERROR_OUT(err), .IRQ(irq));
    pulse_meter_model #(.WINDOW(400)) meter_u (.clk(clk), .arst_n(arst_n), .sync_in(sync),
        .pulse_in(pulse), .n_trig(n_trig), .p_lead(m_lead), .p_width(m_width),
        .p_period(m_period));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            $display("mismatch timeout expected end seen hang");
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        wb_sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        check("bus ack", {31'h0, wb_ack}, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        wb(1'b1, adr, wd, d);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] msk,
                          input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, adr, 32'h0, d);
        check(what, d & msk, exp);
    endtask

    task automatic t_reset;
        logic [7:0]  ofs [11] = '{OFS_CTRL, OFS_WIDTH, OFS_PERIOD, OFS_DELAY1, OFS_START,
            OFS_STOP, OFS_STEP_SIZE, OFS_STEP_TIME, OFS_STATUS, OFS_IRQ_MASK, 8'h30};
        logic [31:0] val [11] = '{{28'h0, RST_CTRL}, RST_WIDTH, RST_PERIOD, RST_DELAY1,
            RST_START, RST_STOP, RST_STEP_SIZE, RST_STEP_TIME, 32'h0, 32'h0, 32'h0};
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 11; i++) rd_chk("reset value", ofs[i], 32'hffff_ffff, val[i]);
        check("error pin", {31'h0, err}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_plain;
        wr(OFS_WIDTH, 32'h3);
        wr(OFS_PERIOD, 32'ha);
        wr(OFS_CTRL, 32'h1);
        repeat (70) @(posedge clk);
        check("period clocks", m_period, 32'd20);
        check("width clocks", m_width, 32'd6);
        // Pulse trails sync by one clock of output register
        check("lead clocks", m_lead, 32'd1);
        check("masked irq", {31'h0, irq}, 32'h0);
        $display("test plain done");
    endtask

    task automatic t_delay;
        wr(OFS_DELAY1, 32'h4);
        wr(OFS_WIDTH, 32'h1);
        wr(OFS_CTRL, 32'h3);
        repeat (70) @(posedge clk);
        check("delayed lead", m_lead, 32'd9);
        check("one tick width", m_width, 32'd2);
        $display("test delay done");
    endtask

    task automatic t_error;
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_DELAY1, 32'h8);
        wr(OFS_WIDTH, 32'h3);
        repeat (4) @(posedge clk);
        check("error raised", {31'h0, err}, 32'h1);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd_chk("error event", OFS_STATUS, 32'h2, 32'h2);
        wr(OFS_PERIOD, 32'hb);
        repeat (4) @(posedge clk);
        check("error cleared", {31'h0, err}, 32'h0);
        wr(OFS_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk("event cleared", OFS_STATUS, 32'h2, 32'h0);
        $display("test error done");
    endtask

    task automatic t_fixed;
        wr(OFS_START, 32'h2);
        wr(OFS_DELAY1, 32'h5);
        // Delay is taken only at the next period start
        repeat (24) @(posedge clk);
        for (int i = 0; i < 10; i++) rd_chk("fixed delay", OFS_CUR_DELAY, 32'hff, 32'h5);
        $display("test fixed done");
    endtask

    task automatic t_sweep(input logic [31:0] st, input logic [31:0] sp, input logic [31:0] sz,
                           input logic [31:0] exp [5]);
        logic [31:0] got [$];
        logic [31:0] d;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_START, st);
        wr(OFS_STOP, sp);
        wr(OFS_STEP_SIZE, sz);
        wr(OFS_STEP_TIME, 32'h28);
        wr(OFS_DELAY1, st);
        wr(OFS_WIDTH, 32'h1);
        wr(OFS_PERIOD, 32'ha);
        wr(OFS_STATUS, 32'h4);
        wr(OFS_CTRL, 32'h7);
        repeat (4) @(posedge clk);
        for (int k = 0; k < 400 && got.size() < 5; k++) begin
            wb(1'b0, OFS_CUR_DELAY, 32'h0, d);
            if (got.size() == 0 || got[$] !== d) got.push_back(d);
        end
        for (int k = 0; k < 5; k++) check("sweep value", got[k], exp[k]);
        rd_chk("wrap event", OFS_STATUS, 32'h4, 32'h4);
        wr(OFS_CTRL, 32'h0);
        $display("test sweep done");
    endtask

    task automatic t_ext;
        int n0;
        wr(OFS_CTRL, 32'h9);
        repeat (40) @(posedge clk);
        n0 = n_trig;
        for (int i = 1; i <= 2; i++) begin
            ext_trig <= 1'b1;
            repeat (4) @(posedge clk);
            ext_trig <= 1'b0;
            repeat (60) @(posedge clk);
            check("ext periods", n_trig - n0, i);
        end
        $display("test ext done");
    endtask

    initial begin
        t_reset();
        t_plain();
        t_delay();
        t_error();
        t_fixed();
        t_sweep(32'h2, 32'h6, 32'h2, '{32'h2, 32'h4, 32'h6, 32'h2, 32'h4});
        t_sweep(32'h6, 32'h1, 32'h2, '{32'h6, 32'h4, 32'h2, 32'h1, 32'h6});
        t_ext();
        t_reset();
        end_of_test();
    end
endmodule

bind pulse_timer pulse_timer_properties #(.CNT_W(CNT_W)) chk_u (.CLK(CLK), .ARST_N(ARST_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .EXT_TRIG(EXT_TRIG), .PULSE_OUT(PULSE_OUT), .SYNC_OUT(SYNC_OUT), .ERROR_OUT(ERROR_OUT),
    .IRQ(IRQ));
`default_nettype wire
